// >>> rtl/erfb_consts.vh
`ifndef ERFB_CONSTS_VH
`define ERFB_CONSTS_VH

// Frame bytes
`define ERFB_START_DELIM     8'h7e
`define ERFB_TYPE_EXPLICIT   8'h91
`define ERFB_TYPE_STANDARD   8'h90
`define ERFB_UNUSED_HI       8'hff
`define ERFB_UNUSED_LO       8'hfe
`define ERFB_CSUM_BASE       8'hff

// Byte positions within the frame
`define ERFB_POS_DELIM       16'd0
`define ERFB_POS_LEN_HI      16'd1
`define ERFB_POS_LEN_LO      16'd2
`define ERFB_POS_TYPE        16'd3
`define ERFB_POS_ADDR_FIRST  16'd4
`define ERFB_POS_ADDR_LAST   16'd11
`define ERFB_POS_UNUSED_HI   16'd12
`define ERFB_POS_UNUSED_LO   16'd13
`define ERFB_POS_SRC_EP      16'd14
`define ERFB_POS_DST_EP      16'd15
`define ERFB_POS_CLUSTER_HI  16'd16
`define ERFB_POS_CLUSTER_LO  16'd17
`define ERFB_POS_PROFILE_HI  16'd18
`define ERFB_POS_PROFILE_LO  16'd19
`define ERFB_POS_OPTIONS_X   16'd20
`define ERFB_POS_OPTIONS_S   16'd14
`define ERFB_HDR_LEN_X       16'd21
`define ERFB_HDR_LEN_S       16'd15

// Receive option fields
`define ERFB_OPT_ACK_BIT     0
`define ERFB_OPT_BCAST_BIT   1
`define ERFB_OPT_METHOD_LSB  6
`define ERFB_METHOD_INVALID  2'b00
`define ERFB_VENDOR_EP_LO    8'hdc
`define ERFB_VENDOR_EP_HI    8'hee
`define ERFB_EXPLICIT_BIT    1

// Register map (byte addresses)
`define ERFB_REG_CTRL        4'h0
`define ERFB_REG_STATUS      4'h4
`define ERFB_REG_FRAMES      4'h8
`define ERFB_CTRL_RESET      8'h00
`define ERFB_ST_BUSY         0
`define ERFB_ST_OVERFLOW     1
`define ERFB_ST_BAD_METHOD   2
`define ERFB_ST_EXPLICIT     3
`define ERFB_RESP_OKAY       2'b00
`define ERFB_RESP_SLVERR     2'b10

`endif

// >>> rtl/erfb_framer.v
`timescale 1ns/10ps
`include "erfb_consts.vh"
module erfb_framer #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire        clock,
  input  wire        rst,
  // Packet description from the radio side
  input  wire        rx_hdr_valid,
  output reg         rx_hdr_ready_ff,
  input  wire [63:0] rx_src_addr,
  input  wire [7:0]  rx_src_ep,
  input  wire [7:0]  rx_dst_ep,
  input  wire [15:0] rx_cluster,
  input  wire [15:0] rx_profile,
  input  wire        rx_acked,
  input  wire        rx_bcast,
  input  wire [1:0]  rx_method,
  // Payload bytes
  input  wire        rx_valid,
  output reg         rx_ready_ff,
  input  wire [7:0]  rx_data,
  input  wire        rx_last,
  // Serial byte stream to the host
  output wire        tx_valid,
  input  wire        tx_ready,
  output wire [7:0]  tx_data,
  output wire        tx_last,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CAPT = 2'b01;
  localparam ST_EMIT = 2'b10;

  reg  [1:0]    state_ff;
  reg  [7:0]    out_opts_ff;
  reg  [1:0]    framing_ff;
  reg           overflow_ff;
  reg           bad_method_ff;
  reg  [15:0]   frames_ff;
  reg           explicit_ff;
  reg  [63:0]   addr_ff;
  reg  [7:0]    src_ep_ff;
  reg  [7:0]    dst_ep_ff;
  reg  [15:0]   cluster_ff;
  reg  [15:0]   profile_ff;
  reg  [7:0]    opts_ff;
  reg  [15:0]   pay_cnt_ff;
  reg  [15:0]   pos_ff;
  reg  [15:0]   nxt_pos;
  reg  [7:0]    sum_ff;
  reg  [7:0]    hdr_byte;
  reg  [7:0]    out_byte;
  reg  [63:0]   addr_shift;
  reg           aw_held_ff;
  reg           w_held_ff;
  reg  [3:0]    awaddr_ff;
  reg  [31:0]   wdata_ff;
  reg  [3:0]    wstrb_ff;
  wire [7:0]    mem_rd_data;
  wire          buf_ready;
  wire [8:0]    buf_out;

  // In explicit frames, receive option meaning holds only inside the vendor endpoint range
  function in_vendor_range;
    input [7:0] ep;
    begin
      in_vendor_range = (ep >= `ERFB_VENDOR_EP_LO) && (ep <= `ERFB_VENDOR_EP_HI);
    end
  endfunction

  function [7:0] build_opts;
    input       acked;
    input       bcast;
    input [1:0] method;
    begin
      build_opts = 8'h00;
      build_opts[`ERFB_OPT_ACK_BIT] = acked;
      build_opts[`ERFB_OPT_BCAST_BIT] = bcast;
      build_opts[`ERFB_OPT_METHOD_LSB+1:`ERFB_OPT_METHOD_LSB] = method;
    end
  endfunction

  wire [15:0] hdr_len  = explicit_ff ? `ERFB_HDR_LEN_X : `ERFB_HDR_LEN_S;
  wire [15:0] frm_len  = pay_cnt_ff + hdr_len - `ERFB_POS_TYPE;
  wire [15:0] csum_pos = hdr_len + pay_cnt_ff;
  wire        in_pay   = (pos_ff >= hdr_len) && (pos_ff < csum_pos);
  wire        is_csum  = (pos_ff == csum_pos);
  wire        push     = (state_ff == ST_EMIT) && buf_ready;
  wire        hdr_take = rx_hdr_valid && rx_hdr_ready_ff;
  wire        pay_take = rx_valid && rx_ready_ff;
  wire        pay_room = (pay_cnt_ff < DEPTH);
  wire        wr_fire  = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire        ctrl_hit = (awaddr_ff == `ERFB_REG_CTRL);
  wire        stat_hit = (awaddr_ff == `ERFB_REG_STATUS);
  wire        explicit_sel = out_opts_ff[`ERFB_EXPLICIT_BIT] && (out_opts_ff > 8'h01);

  // Header byte selection, most significant byte first
  always @* begin
    addr_shift = addr_ff << {pos_ff[2:0] - 3'h4, 3'h0};
    case (pos_ff)
      `ERFB_POS_DELIM:      hdr_byte = `ERFB_START_DELIM;
      `ERFB_POS_LEN_HI:     hdr_byte = frm_len[15:8];
      `ERFB_POS_LEN_LO:     hdr_byte = frm_len[7:0];
      `ERFB_POS_TYPE:       hdr_byte = explicit_ff ? `ERFB_TYPE_EXPLICIT : `ERFB_TYPE_STANDARD;
      `ERFB_POS_UNUSED_HI:  hdr_byte = `ERFB_UNUSED_HI;
      `ERFB_POS_UNUSED_LO:  hdr_byte = `ERFB_UNUSED_LO;
      `ERFB_POS_SRC_EP:     hdr_byte = explicit_ff ? src_ep_ff : opts_ff;
      `ERFB_POS_DST_EP:     hdr_byte = dst_ep_ff;
      `ERFB_POS_CLUSTER_HI: hdr_byte = cluster_ff[15:8];
      `ERFB_POS_CLUSTER_LO: hdr_byte = cluster_ff[7:0];
      `ERFB_POS_PROFILE_HI: hdr_byte = profile_ff[15:8];
      `ERFB_POS_PROFILE_LO: hdr_byte = profile_ff[7:0];
      `ERFB_POS_OPTIONS_X:  hdr_byte = opts_ff;
      default:              hdr_byte = addr_shift[63:56];
    endcase
    if (is_csum) begin
      out_byte = `ERFB_CSUM_BASE - sum_ff;
    end else if (in_pay) begin
      out_byte = mem_rd_data;
    end else begin
      out_byte = hdr_byte;
    end
  end

  // Memory read address runs one step ahead so data meets pos_ff
  always @* begin
    nxt_pos = pos_ff;
    if (state_ff == ST_IDLE) begin
      nxt_pos = 16'h0000;
    end else if (push) begin
      nxt_pos = pos_ff + 16'h0001;
    end
  end
  wire [15:0] rd_idx = nxt_pos - hdr_len;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff        <= ST_IDLE;
      rx_hdr_ready_ff <= 1'b1;
      rx_ready_ff     <= 1'b0;
      explicit_ff     <= 1'b0;
      addr_ff         <= 64'h0;
      src_ep_ff       <= 8'h00;
      dst_ep_ff       <= 8'h00;
      cluster_ff      <= 16'h0000;
      profile_ff      <= 16'h0000;
      opts_ff         <= 8'h00;
      pay_cnt_ff      <= 16'h0000;
      pos_ff          <= 16'h0000;
      sum_ff          <= 8'h00;
      frames_ff       <= 16'h0000;
    end else begin
      pos_ff <= nxt_pos;
      case (state_ff)
        ST_IDLE: begin
          if (hdr_take) begin
            explicit_ff     <= explicit_sel;
            addr_ff         <= rx_src_addr;
            src_ep_ff       <= rx_src_ep;
            dst_ep_ff       <= rx_dst_ep;
            cluster_ff      <= rx_cluster;
            profile_ff      <= rx_profile;
            // In explicit frames, outside the vendor range the option bits carry no meaning and are zeroed
            opts_ff         <= (!explicit_sel || in_vendor_range(rx_dst_ep)) ?
                               build_opts(rx_acked, rx_bcast, rx_method) : 8'h00;
            pay_cnt_ff      <= 16'h0000;
            sum_ff          <= 8'h00;
            rx_hdr_ready_ff <= 1'b0;
            rx_ready_ff     <= 1'b1;
            state_ff        <= ST_CAPT;
          end
        end
        ST_CAPT: begin
          if (pay_take) begin
            // Bytes beyond the buffer depth are dropped
            if (pay_room) begin
              pay_cnt_ff <= pay_cnt_ff + 16'h0001;
            end
            if (rx_last) begin
              rx_ready_ff <= 1'b0;
              state_ff    <= ST_EMIT;
            end
          end
        end
        ST_EMIT: begin
          if (push) begin
            if (pos_ff >= `ERFB_POS_TYPE && !is_csum) begin
              sum_ff <= sum_ff + out_byte;
            end
            if (is_csum) begin
              frames_ff       <= frames_ff + 16'h0001;
              rx_hdr_ready_ff <= 1'b1;
              state_ff        <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff        <= ST_IDLE;
          rx_hdr_ready_ff <= 1'b1;
          rx_ready_ff     <= 1'b0;
        end
      endcase
    end
  end

  erfb_payload_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clock      (clock),
    .wr_en      (pay_take && pay_room && (state_ff == ST_CAPT)),
    .wr_addr    (pay_cnt_ff[AW-1:0]),
    .wr_data    (rx_data),
    .rd_addr    (rd_idx[AW-1:0]),
    .rd_data_ff (mem_rd_data)
  );

  // Host stall fills the buffer and holds the sequencer
  erfb_skid_buf #(
    .WIDTH (9)
  ) u_buf (
    .clock        (clock),
    .rst          (rst),
    .in_valid     (state_ff == ST_EMIT),
    .in_data      ({is_csum, out_byte}),
    .in_ready_ff  (buf_ready),
    .out_valid_ff (tx_valid),
    .out_data_ff  (buf_out),
    .out_ready    (tx_ready)
  );
  assign tx_data = buf_out[7:0];
  assign tx_last = buf_out[8];

  // Register write channel: address and data taken in either order
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ERFB_RESP_OKAY;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 4'h0;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff    <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff    <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ctrl_hit || stat_hit || awaddr_ff == `ERFB_REG_FRAMES) ?
                        `ERFB_RESP_OKAY : `ERFB_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control and sticky status; a new event wins over a clear
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      out_opts_ff   <= `ERFB_CTRL_RESET;
      framing_ff    <= 2'b00;
      overflow_ff   <= 1'b0;
      bad_method_ff <= 1'b0;
    end else begin
      if (wr_fire && ctrl_hit && wstrb_ff[0]) begin
        out_opts_ff <= wdata_ff[7:0];
      end
      if (wr_fire && ctrl_hit && wstrb_ff[1]) begin
        framing_ff <= wdata_ff[9:8];
      end
      if (wr_fire && stat_hit && wstrb_ff[0] && wdata_ff[`ERFB_ST_OVERFLOW]) begin
        overflow_ff <= 1'b0;
      end
      if (wr_fire && stat_hit && wstrb_ff[0] && wdata_ff[`ERFB_ST_BAD_METHOD]) begin
        bad_method_ff <= 1'b0;
      end
      if (state_ff == ST_CAPT && pay_take && !pay_room) begin
        overflow_ff <= 1'b1;
      end
      if (hdr_take && rx_method == `ERFB_METHOD_INVALID) begin
        bad_method_ff <= 1'b1;
      end
    end
  end

  // Register read channel, answer one cycle after address
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ERFB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `ERFB_RESP_OKAY;
        case (s_axi_araddr)
          `ERFB_REG_CTRL:   s_axi_rdata <= {22'h0, framing_ff, out_opts_ff};
          `ERFB_REG_STATUS: s_axi_rdata <= {28'h0, explicit_ff, bad_method_ff, overflow_ff,
                                            state_ff != ST_IDLE};
          `ERFB_REG_FRAMES: s_axi_rdata <= {16'h0, frames_ff};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ERFB_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// >>> rtl/erfb_payload_mem.v
`timescale 1ns/10ps
module erfb_payload_mem #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire          clock,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data_ff
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule

// >>> rtl/erfb_skid_buf.v
`timescale 1ns/10ps
// Two-entry buffer; head entry drives the outputs directly from flops
module erfb_skid_buf #(
  parameter WIDTH = 9
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready_ff,
  output reg              out_valid_ff,
  output reg  [WIDTH-1:0] out_data_ff,
  input  wire             out_ready
);
  reg             spare_valid_ff;
  reg [WIDTH-1:0] spare_data_ff;
  wire            push = in_valid && in_ready_ff;
  wire            pop  = out_valid_ff && out_ready;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid_ff   <= 1'b0;
      out_data_ff    <= {WIDTH{1'b0}};
      spare_valid_ff <= 1'b0;
      spare_data_ff  <= {WIDTH{1'b0}};
      in_ready_ff    <= 1'b1;
    end else begin
      if (pop) begin
        if (spare_valid_ff) begin
          out_data_ff    <= spare_data_ff;
          spare_valid_ff <= push;
          spare_data_ff  <= in_data;
        end else begin
          out_valid_ff <= push;
          out_data_ff  <= in_data;
        end
      end else if (push) begin
        if (out_valid_ff) begin
          spare_valid_ff <= 1'b1;
          spare_data_ff  <= in_data;
        end else begin
          out_valid_ff <= 1'b1;
          out_data_ff  <= in_data;
        end
      end
      // Ready drops once both entries will be full
      in_ready_ff <= !((out_valid_ff || push) && (spare_valid_ff || (push && out_valid_ff && !pop))
                       && !(pop && !spare_valid_ff));
    end
  end
endmodule

// >>> tb/erfb_framer_properties.sv
`timescale 1ns/10ps
module erfb_framer_properties (
  input wire       clock,
  input wire       rst,
  input wire       rx_hdr_valid,
  input wire       rx_hdr_ready_ff,
  input wire       rx_ready_ff,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire [7:0] tx_data,
  input wire       tx_last,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready
);
  reg [15:0] idx_ff;
  reg [15:0] len_ff;
  reg [7:0]  sum_ff;
  reg        expl_ff;
  wire       hs = tx_valid && tx_ready;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_ff <= 16'h0;
      len_ff <= 16'h0;
      sum_ff <= 8'h0;
      expl_ff <= 1'b0;
    end else if (hs) begin
      idx_ff <= tx_last ? 16'h0 : idx_ff + 16'h1;
      sum_ff <= (idx_ff < 16'h3) ? 8'h0 : sum_ff + tx_data;
      if (idx_ff == 16'h1) len_ff[15:8] <= tx_data;
      if (idx_ff == 16'h2) len_ff[7:0] <= tx_data;
      if (idx_ff == 16'h3) expl_ff <= (tx_data == 8'h91);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_hdr_take;
    rx_hdr_valid && rx_hdr_ready_ff;
  endsequence
  sequence s_payload_open;
    rx_ready_ff && !rx_hdr_ready_ff;
  endsequence
  a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx byte changed while stalled");
  a_delim_first: assert property (tx_valid && idx_ff == 16'h0 |-> tx_data == 8'h7e)
    else $error("frame does not open with delimiter");
  a_type_code: assert property (tx_valid && idx_ff == 16'h3 |-> tx_data == 8'h91 || tx_data == 8'h90)
    else $error("bad frame type byte");
  a_unused_field: assert property (tx_valid && idx_ff == 16'hd |-> tx_data == 8'hfe)
    else $error("unused field low byte wrong");
  a_unused_high: assert property (tx_valid && idx_ff == 16'hc |-> tx_data == 8'hff)
    else $error("unused field high byte wrong");
  a_opt_reserved: assert property (tx_valid && expl_ff && idx_ff == 16'h14 |-> tx_data[5:2] == 4'h0)
    else $error("reserved option bits set");
  a_length_count: assert property (tx_valid && tx_last |-> idx_ff == len_ff + 16'h3)
    else $error("length field disagrees with frame");
  a_checksum_value: assert property (tx_valid && tx_last |-> tx_data == 8'hff - sum_ff)
    else $error("checksum byte wrong");
  a_payload_place: assert property (tx_valid && tx_last && expl_ff |-> idx_ff >= 16'h16)
    else $error("explicit frame without payload");
  a_hdr_then_data: assert property (s_hdr_take |=> s_payload_open)
    else $error("payload not opened after header");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind erfb_framer erfb_framer_properties erfb_framer_properties_i (
  .clock(clock), .rst(rst), .rx_hdr_valid(rx_hdr_valid), .rx_hdr_ready_ff(rx_hdr_ready_ff),
  .rx_ready_ff(rx_ready_ff), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .tx_last(tx_last), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// >>> tb/erfb_framer_tb_top.sv
`timescale 1ns/10ps
module erfb_framer_tb_top;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         rx_hdr_valid = 1'b0, rx_acked = 1'b0, rx_bcast = 1'b0;
  reg  [1:0]  rx_method = 2'h0;
  reg  [7:0]  rx_dst_ep = 8'h0, rx_data = 8'h0;
  reg         rx_valid = 1'b0, rx_last = 1'b0, stall = 1'b0;
  reg  [3:0]  awaddr = 4'h0, araddr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire        rx_hdr_ready_ff, rx_ready_ff, tx_valid, tx_ready, tx_last;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [7:0]  tx_data;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  int         n_mismatch = 0, total_checks = 0, cyc = 0;
  logic [7:0] exp_q [$];
  always #5 clock = ~clock;
  erfb_framer erfb_framer_i (.clock(clock), .rst(rst), .rx_hdr_valid(rx_hdr_valid),
    .rx_hdr_ready_ff(rx_hdr_ready_ff), .rx_src_addr(64'h0102_0304_a5b6_c7d8), .rx_src_ep(8'he8),
    .rx_dst_ep(rx_dst_ep), .rx_cluster(16'h0011), .rx_profile(16'h5a3c), .rx_acked(rx_acked),
    .rx_bcast(rx_bcast), .rx_method(rx_method), .rx_valid(rx_valid), .rx_ready_ff(rx_ready_ff),
    .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  erfb_host_model erfb_host_model_i (.clock(clock), .rst(rst), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task axi_write(input [3:0] a, input [31:0] d, input [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", bresp, er);
    // Let an edge pass so a following call never re-drives bready in this step
    @(posedge clock);
  endtask
  task axi_read(input [3:0] a, input [31:0] ed, input [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("read data", rdata, ed);
    check("read response", rresp, er);
    @(posedge clock);
  endtask
  // Explicit when the output setting has bit 1 set; options zeroed off the vendor endpoints in explicit frames only
  task send(input [7:0] dep, input [1:0] m, input ack, input bc, input int npl, input expl);
    logic [15:0] ln;
    logic [7:0]  op, cs;
    int          nf;
    op = {m, 4'h0, bc, ack};
    if (expl && (dep < 8'hdc || dep > 8'hee)) op = 8'h0;
    ln = npl[15:0] + (expl ? 16'd18 : 16'd12);
    exp_q = {8'h7e, ln[15:8], ln[7:0], expl ? 8'h91 : 8'h90, 8'h01, 8'h02, 8'h03, 8'h04};
    exp_q = {exp_q, 8'ha5, 8'hb6, 8'hc7, 8'hd8, 8'hff, 8'hfe};
    if (expl) exp_q = {exp_q, 8'he8, dep, 8'h00, 8'h11, 8'h5a, 8'h3c};
    exp_q.push_back(op);
    for (int k = 0; k < npl; k++) exp_q.push_back(8'h30 + k[7:0]);
    cs = 8'h0;
    for (int k = 3; k < exp_q.size(); k++) cs = cs + exp_q[k];
    exp_q.push_back(8'hff - cs);
    nf = erfb_host_model_i.n_frames;
    rx_dst_ep <= dep;
    rx_method <= m;
    rx_acked <= ack;
    rx_bcast <= bc;
    rx_hdr_valid <= 1'b1;
    do @(posedge clock); while (rx_hdr_ready_ff !== 1'b1);
    rx_hdr_valid <= 1'b0;
    for (int k = 0; k < npl; k++) begin
      rx_valid <= 1'b1;
      rx_data <= 8'h30 + k[7:0];
      rx_last <= (k == npl - 1);
      do @(posedge clock); while (rx_ready_ff !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    while (erfb_host_model_i.n_frames == nf) @(posedge clock);
    @(posedge clock);
    check("frame length", erfb_host_model_i.flen, exp_q.size());
    for (int k = 0; k < exp_q.size(); k++) check("frame byte", erfb_host_model_i.got[k], exp_q[k]);
    check("host checksum", erfb_host_model_i.csum_bad, 1'b0);
  endtask
  logic [7:0] ctl_t [0:5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h02, 8'h02};
  logic [7:0] dep_t [0:5] = '{8'he8, 8'he8, 8'hee, 8'h10, 8'hdc, 8'hdb};
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    axi_read(4'h0, 32'h0, 2'b00);
    axi_read(4'hc, 32'h0, 2'b10);
    axi_write(4'hc, 32'h3, 2'b10);
    for (int i = 0; i < 6; i++) begin
      stall <= i[0];
      axi_write(4'h0, {24'h0, ctl_t[i]}, 2'b00);
      axi_read(4'h0, {24'h0, ctl_t[i]}, 2'b00);
      send(dep_t[i], i[1:0], i[0], i[1], i + 1, ctl_t[i][1]);
    end
    send(8'he8, 2'b11, 1'b1, 1'b0, 6, 1'b1);
    axi_read(4'h4, 32'hc, 2'b00);
    axi_write(4'h4, 32'h4, 2'b00);
    axi_read(4'h4, 32'h8, 2'b00);
    axi_read(4'h8, 32'h7, 2'b00);
    tally_and_finish;
  end
endmodule

// >>> tb/erfb_host_model.sv
`timescale 1ns/10ps
module erfb_host_model (
  input  wire       clock,
  input  wire       rst,
  input  wire       stall,
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  input  wire       tx_last,
  output reg        tx_ready
);
  logic [7:0] got [0:299];
  int         n_got;
  int         flen;
  int         n_frames;
  logic [7:0] sum;
  logic       csum_bad;
  logic [2:0] tick;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      n_got <= 0;
      n_frames <= 0;
      sum <= 8'h0;
      csum_bad <= 1'b0;
      tick <= 3'h0;
    end else begin
      tick <= tick + 3'h1;
      // Slow reader while stall is set: ready only half the time
      tx_ready <= !stall || tick[1];
      if (tx_valid && tx_ready) begin
        got[n_got] <= tx_data;
        n_got <= tx_last ? 0 : n_got + 1;
        sum <= (n_got < 3) ? 8'h0 : sum + tx_data;
        if (tx_last) begin
          flen <= n_got + 1;
          n_frames <= n_frames + 1;
          if (tx_data !== 8'hff - sum) csum_bad <= 1'b1;
        end
      end
    end
  end
endmodule
